// File: hdl/adcs_pkg.sv
// constants and types for the converter sequencer
// assumes a 200 MHz system clock and an external sar comparator path
`default_nettype none
package adcs_pkg;
	localparam int          DATA_W          = 8;
	localparam int          CH_W            = 3;
	localparam int          CHSEL_W         = 4;
	localparam int          ENTRIES         = 4;
	localparam int          PTR_W           = 2;
	localparam int          DIV_W           = 8;
	localparam int          DLY_W           = 8;
	localparam int          CNT_W           = 4;
	localparam int          CLK_HZ          = 200_000_000;
	localparam int          CONV_CLK_MAX_HZ = 1_000_000;
	localparam logic [DIV_W-1:0] DIV_MIN_M1 =
		DIV_W'((CLK_HZ + CONV_CLK_MAX_HZ - 1) / CONV_CLK_MAX_HZ - 1);
	localparam logic [CNT_W-1:0] CONV_CLOCKS = 4'ha;
	localparam logic [CNT_W-1:0] CONV_LAST   = 4'h9;
	localparam logic [CNT_W-1:0] CNT_ZERO    = 4'h0;
	localparam logic [1:0]  SWEEP_SINGLE    = 2'h0;
	localparam logic [1:0]  SWEEP_SCAN      = 2'h1;
	localparam logic [PTR_W-1:0] PTR_START  = 2'h3;
	localparam logic [PTR_W-1:0] PTR_LAST   = 2'h3;
	localparam logic [DATA_W-1:0] CODE_ZERO = 8'h00;
	localparam logic [DATA_W-1:0] CODE_MSB  = 8'h80;
	localparam logic [DLY_W-1:0] DLY_ZERO   = 8'h00;
	localparam logic [DIV_W-1:0] DIV_ZERO   = 8'h00;

	typedef enum logic [1:0] {
		ADCS_IDLE    = 2'b00,
		ADCS_SETTLE  = 2'b01,
		ADCS_CONVERT = 2'b11,
		ADCS_STORE   = 2'b10
	} adcs_state_e;
endpackage
`default_nettype wire

// File: hdl/adcs_sar.sv
// converter clock divider and successive-approximation engine
// assumes the comparator input is already synchronised to clk
`default_nettype none
module adcs_sar
	import adcs_pkg::*;
(
	// clock and reset
	input  wire logic              clk,
	input  wire logic              rstn,
	// control
	input  wire logic [DIV_W-1:0]  div_factor,
	input  wire logic              go,
	input  wire logic              abort,
	input  wire logic              cmp_sync,
	// status
	output logic                   conv_tick,
	output logic                   done,
	output logic [DATA_W-1:0]      result,
	output logic [DATA_W-1:0]      dac_code
);
	logic [DIV_W-1:0]  div_q;
	logic              tick_q;
	logic              act_q;
	logic [CNT_W-1:0]  cnt_q;
	logic [DATA_W-1:0] code_q;
	logic [DATA_W-1:0] res_q;
	logic              done_q;
	logic [DIV_W-1:0]  div_eff;
	logic [CNT_W-1:0]  bpos;
	logic              trial;

	// converter clock never faster than its limit
	assign div_eff = (div_factor < DIV_MIN_M1) ? DIV_MIN_M1 : div_factor; // RL4
	assign bpos    = CNT_W'(DATA_W) - cnt_q;
	assign trial   = (cnt_q != CNT_ZERO) && (cnt_q <= CNT_W'(DATA_W));

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			div_q  <= DIV_ZERO;
			tick_q <= 1'b0;
		end
		else
		begin
			tick_q <= (div_q == DIV_ZERO); // RL3
			div_q  <= (div_q == DIV_ZERO) ? div_eff : div_q - 1'b1; // RL3
		end
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			act_q  <= 1'b0;
			cnt_q  <= CNT_ZERO;
			code_q <= CODE_ZERO;
			res_q  <= CODE_ZERO;
			done_q <= 1'b0;
		end
		else
		begin
			done_q <= 1'b0;
			if (abort)
				act_q <= 1'b0;
			else if (go)
			begin
				act_q  <= 1'b1;
				cnt_q  <= CNT_ZERO;
				code_q <= CODE_ZERO;
			end
			else if (act_q && tick_q)
			begin
				cnt_q <= cnt_q + 1'b1;
				if (cnt_q == CNT_ZERO)
					code_q <= CODE_MSB;
				else if (trial)
				begin
					code_q[bpos[2:0]] <= cmp_sync; // RL2
					if (bpos[2:0] != 3'h0)
						code_q[bpos[2:0] - 3'h1] <= 1'b1;
				end
				if (cnt_q == CONV_LAST)
				begin
					act_q  <= 1'b0;
					done_q <= 1'b1; // RL4
					res_q  <= code_q;
				end
			end
		end
	end

	assign conv_tick = tick_q;
	assign done      = done_q;
	assign result    = res_q;
	assign dac_code  = code_q;

	// ticks since go, read only by the check below
	logic [CNT_W-1:0] hlp_q;
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			hlp_q <= CNT_ZERO;
		else if (go)
			hlp_q <= CNT_ZERO;
		else if (act_q && tick_q)
			hlp_q <= hlp_q + 1'b1;
	end

	property p_conv_len;
		@(posedge clk) disable iff (!rstn)
		done |-> (hlp_q == CONV_CLOCKS);
	endproperty
	a_conv_len: assert property (p_conv_len) else $error("conversion not ten converter clocks"); // RL4
endmodule
`default_nettype wire

// File: hdl/adcs_seq.sv
// sequencer for an eight-input 8-bit successive-approximation converter
// assumes control strobes come from logic on clk, comparator from the analog core
// Notes on behaviour
// RL1 - each conversion routes one of eight inputs through the multiplexer
// RL2 - result is unsigned 8-bit, 0x00 at zero volts, 0xFF at reference
// RL3 - converter clock is the system clock through a programmable divider
// RL4 - a conversion takes ten converter clocks, kept at or below 1 MHz
// RL5 - sampling delay before every conversion, no other pause between conversions
// RL6 - software waits 100 us after enabling before starting
// RL7 - four-entry result buffer, one channel repeated or four adjacent channels
// RL8 - mode decoded from sweep field and repeat bit
// RL9 - software disables the converter before changing mode
// RL10 - single one-shot writes entry 0, clears start, sets completion
// RL11 - completion flag with interrupt enable raises the interrupt request
// RL12 - single continuous fills entries 0 to 3, completion after entry 3
// RL13 - continuous keeps start set and wraps from entry 3 to entry 0
// RL14 - software reads results before the wrap to avoid overrun
// RL15 - clearing start in single continuous finishes current conversion then stops
// RL16 - 2-bit pointer names the entry with the newest result
// RL17 - pointer loads 11 on start rising, increments per result
// RL18 - writing a full entry overwrites and sets sticky flag, write 1 clears
// RL19 - disabling aborts and clears completion, busy, overflow and start
// RL20 - four-channel modes scan adjacent channels, one-shot clears start after entry 3
// RL21 - any result read clears completion; busy while not idle
`default_nettype none
module adcs_seq
	import adcs_pkg::*;
(
	// clock and reset
	input  wire logic               clk,
	input  wire logic               rstn,
	// control
	input  wire logic               converter_enable_bit,
	input  wire logic               converter_irq_enable,
	input  wire logic               start_set,
	input  wire logic               start_clear,
	input  wire logic [1:0]         sweep_sel,
	input  wire logic               repeat_select_bit,
	input  wire logic [CHSEL_W-1:0] channel_sel,
	input  wire logic [DIV_W-1:0]   clk_div,
	input  wire logic [DLY_W-1:0]   sample_delay,
	input  wire logic               overwrite_flag_clear,
	input  wire logic               result_read,
	input  wire logic [PTR_W-1:0]   result_read_idx,
	// status
	output logic                    start_bit,
	output logic                    completion_flag,
	output logic                    busy_flag,
	output logic                    overwrite_flag,
	output logic [PTR_W-1:0]        last_result_pointer,
	output logic                    converter_irq,
	output logic [DATA_W-1:0]       result_entry_0,
	output logic [DATA_W-1:0]       result_entry_1,
	output logic [DATA_W-1:0]       result_entry_2,
	output logic [DATA_W-1:0]       result_entry_3,
	// analog core
	input  wire logic               cmp_in,
	output logic [CH_W-1:0]         mux_sel,
	output logic                    sample_hold,
	output logic [DATA_W-1:0]       dac_code
);
	adcs_state_e       state_q;
	adcs_state_e       state_d;
	logic              cmp_s1_q;
	logic              cmp_s2_q;
	logic              start_q;
	logic              scan_q;
	logic              rep_q;
	logic [CH_W-1:0]   base_q;
	logic [PTR_W-1:0]  ptr_q;
	logic [DLY_W-1:0]  dly_q;
	logic              eoc_q;
	logic              eoc_d;
	logic              ovf_q;
	logic              busy_q;
	logic              irq_q;
	logic [CH_W-1:0]   mux_q;
	logic              sh_q;
	logic [ENTRIES-1:0] full_q;
	logic [DATA_W-1:0] buf_q [ENTRIES];

	logic              en;
	logic              tick;
	logic              conv_done;
	logic [DATA_W-1:0] conv_res;
	logic              start_rise;
	logic [PTR_W-1:0]  next_idx;
	logic              store;
	logic              last_slot;
	logic              stop_now;
	logic              eoc_set;
	logic              ovf_set;
	logic              settle_done;
	logic              reload_dly;
	logic [CH_W-1:0]   chan_now;

	// comparator from the analog side
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			cmp_s1_q <= 1'b0;
			cmp_s2_q <= 1'b0;
		end
		else
		begin
			cmp_s1_q <= cmp_in;
			cmp_s2_q <= cmp_s1_q;
		end
	end

	assign en          = converter_enable_bit;
	assign start_rise  = en && start_set && !start_q && (state_q == ADCS_IDLE);
	assign next_idx    = ptr_q + 1'b1;
	assign store       = en && (state_q == ADCS_STORE);
	assign last_slot   = (next_idx == PTR_LAST);
	// one-shot ends on its last entry, continuous only once start is gone
	assign stop_now    = store && (rep_q ? (!start_q && (!scan_q || last_slot)) // RL15
	                                     : (!scan_q || last_slot)); // RL10 RL20
	assign eoc_set     = store && ((last_slot && (scan_q || rep_q)) || stop_now); // RL12
	assign ovf_set     = store && full_q[next_idx]; // RL18
	assign settle_done = (state_q == ADCS_SETTLE) && tick && (dly_q == DLY_ZERO);
	assign reload_dly  = start_rise || (store && !stop_now);
	// first channel straight from the select, base not yet latched
	assign chan_now    = start_rise ? channel_sel[CH_W-1:0] // RL1
	                                : base_q + (scan_q ? CH_W'(next_idx) : CH_W'(0)); // RL1 RL20

	always_comb
	begin
		state_d = state_q;
		case (state_q)
			ADCS_IDLE:    if (start_rise) state_d = ADCS_SETTLE;
			ADCS_SETTLE:  if (settle_done) state_d = ADCS_CONVERT; // RL5
			ADCS_CONVERT: if (conv_done) state_d = ADCS_STORE;
			ADCS_STORE:   state_d = stop_now ? ADCS_IDLE : ADCS_SETTLE; // RL13
			default:      state_d = ADCS_IDLE;
		endcase
		if (!en)
			state_d = ADCS_IDLE; // RL19
	end

	// set wins over the read clear
	assign eoc_d = !en ? 1'b0 : (eoc_set ? 1'b1 : (result_read ? 1'b0 : eoc_q)); // RL21

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			state_q <= ADCS_IDLE;
			start_q <= 1'b0;
			scan_q  <= 1'b0;
			rep_q   <= 1'b0;
			base_q  <= CH_W'(0);
		end
		else
		begin
			state_q <= state_d;
			if (!en || stop_now)
				start_q <= 1'b0; // RL19 RL10
			else if (start_rise)
				start_q <= 1'b1;
			else if (start_clear)
				start_q <= 1'b0;
			if (start_rise)
			begin
				scan_q <= (sweep_sel == SWEEP_SCAN); // RL8
				rep_q  <= repeat_select_bit; // RL8
				base_q <= channel_sel[CH_W-1:0];
			end
		end
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			ptr_q <= PTR_START;
			dly_q <= DLY_ZERO;
			eoc_q <= 1'b0;
			ovf_q <= 1'b0;
		end
		else
		begin
			if (start_rise)
				ptr_q <= PTR_START; // RL17
			else if (store)
				ptr_q <= next_idx; // RL16 RL17
			if (reload_dly)
				dly_q <= sample_delay; // RL5
			else if ((state_q == ADCS_SETTLE) && tick && (dly_q != DLY_ZERO))
				dly_q <= dly_q - 1'b1;
			eoc_q <= eoc_d;
			if (!en)
				ovf_q <= 1'b0; // RL19
			else if (ovf_set)
				ovf_q <= 1'b1; // RL18
			else if (overwrite_flag_clear)
				ovf_q <= 1'b0; // RL18
		end
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			busy_q <= 1'b0;
			irq_q  <= 1'b0;
			mux_q  <= CH_W'(0);
			sh_q   <= 1'b0;
		end
		else
		begin
			busy_q <= (state_d != ADCS_IDLE); // RL21
			irq_q  <= eoc_d && converter_irq_enable; // RL11
			mux_q  <= chan_now; // RL1
			sh_q   <= (state_d == ADCS_SETTLE);
		end
	end

	// result buffer entries
	genvar gi;
	generate
		for (gi = 0; gi < ENTRIES; gi++)
		begin : g_entry
			always_ff @(posedge clk or negedge rstn)
			begin
				if (!rstn)
				begin
					buf_q[gi]  <= CODE_ZERO;
					full_q[gi] <= 1'b0;
				end
				else if (store && (next_idx == PTR_W'(gi)))
				begin
					buf_q[gi]  <= conv_res; // RL7
					full_q[gi] <= 1'b1;
				end
				else if (!en || (result_read && (result_read_idx == PTR_W'(gi))))
					full_q[gi] <= 1'b0;
			end
		end
	endgenerate

	adcs_sar u_sar (
		.clk        (clk),
		.rstn       (rstn),
		.div_factor (clk_div),
		.go         (settle_done),
		.abort      (!en),
		.cmp_sync   (cmp_s2_q),
		.conv_tick  (tick),
		.done       (conv_done),
		.result     (conv_res),
		.dac_code   (dac_code)
	);

	assign start_bit           = start_q;
	assign completion_flag     = eoc_q;
	assign busy_flag           = busy_q;
	assign overwrite_flag      = ovf_q;
	assign last_result_pointer = ptr_q;
	assign converter_irq       = irq_q;
	assign result_entry_0      = buf_q[0];
	assign result_entry_1      = buf_q[1];
	assign result_entry_2      = buf_q[2];
	assign result_entry_3      = buf_q[3];
	assign mux_sel             = mux_q;
	assign sample_hold         = sh_q;

	// checks
	property p_mux_channel;
		@(posedge clk) disable iff (!rstn)
		(state_q == ADCS_CONVERT) |-> (mux_sel == chan_now);
	endproperty
	a_mux_channel: assert property (p_mux_channel) else $error("wrong channel during conversion"); // RL1

	property p_settle_first;
		@(posedge clk) disable iff (!rstn)
		$rose(state_q == ADCS_CONVERT) |-> ($past(state_q) == ADCS_SETTLE) && $past(sample_hold);
	endproperty
	a_settle_first: assert property (p_settle_first) else $error("conversion without settling"); // RL5

	property p_ptr_load;
		@(posedge clk) disable iff (!rstn)
		start_rise |=> (last_result_pointer == PTR_START) && start_bit && busy_flag;
	endproperty
	a_ptr_load: assert property (p_ptr_load) else $error("pointer not loaded on start"); // RL17

	property p_ptr_inc;
		@(posedge clk) disable iff (!rstn)
		store |=> (last_result_pointer == PTR_W'($past(ptr_q) + 1'b1));
	endproperty
	a_ptr_inc: assert property (p_ptr_inc) else $error("pointer not advanced on result"); // RL16

	property p_ovf_set;
		@(posedge clk) disable iff (!rstn)
		(en && ovf_set) |=> overwrite_flag ##1 (overwrite_flag || $past(overwrite_flag_clear) || !$past(en));
	endproperty
	a_ovf_set: assert property (p_ovf_set) else $error("overwrite flag not set"); // RL18

	property p_disable;
		@(posedge clk) disable iff (!rstn)
		!en |=> !start_bit && !completion_flag && !overwrite_flag && !busy_flag;
	endproperty
	a_disable: assert property (p_disable) else $error("disable did not clear status"); // RL19

	property p_irq;
		@(posedge clk) disable iff (!rstn)
		completion_flag && $past(converter_irq_enable) |-> converter_irq;
	endproperty
	a_irq: assert property (p_irq) else $error("interrupt missing"); // RL11

	property p_oneshot;
		@(posedge clk) disable iff (!rstn)
		(en && store && !rep_q && !scan_q) |=> !start_bit && completion_flag && (state_q == ADCS_IDLE);
	endproperty
	a_oneshot: assert property (p_oneshot) else $error("one-shot did not finish"); // RL10

	property p_repeat_select_bit_keeps;
		@(posedge clk) disable iff (!rstn)
		(en && store && rep_q && start_q) |=> (start_bit || $past(start_clear)) && (state_q == ADCS_SETTLE);
	endproperty
	a_repeat_select_bit_keeps: assert property (p_repeat_select_bit_keeps) else $error("continuous run stopped"); // RL13

	c_oneshot: cover property (@(posedge clk) disable iff (!rstn) store && !rep_q && !scan_q);
	c_scan_end: cover property (@(posedge clk) disable iff (!rstn) store && scan_q && last_slot);
	c_overwrite: cover property (@(posedge clk) disable iff (!rstn) ovf_set);
	c_repeat_select_bit_stop: cover property (@(posedge clk) disable iff (!rstn) stop_now && rep_q);
endmodule
`default_nettype wire

// File: tb/adcs_analog_model.sv
// analog multiplexer, sample-and-hold and comparator model
// assumes clk is the sequencer clock and levels are set by the bench
`default_nettype none
module adcs_analog_model
	import adcs_pkg::*;
(
	// clock
	input  wire logic              clk,
	// sequencer side
	input  wire logic [CH_W-1:0]   mux_sel,
	input  wire logic              sample_hold,
	input  wire logic [DATA_W-1:0] dac_code,
	output logic                   cmp_in
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [DATA_W-1:0] level [8];
	logic [DATA_W-1:0] held = 8'h00;
	// track the routed input while sampling, freeze after
	always @(posedge clk)
		if (sample_hold)
			held <= level[mux_sel];
	// input sits half a step above its code
	assign cmp_in = held >= dac_code;
endmodule
`default_nettype wire

// File: tb/test_adcs_seq.sv
// bench for the converter sequencer with its analog model
// assumes adcs_seq, adcs_analog_model and a 200 MHz clock
`default_nettype none
module test_adcs_seq
	import adcs_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int EN_WAIT = 20000;
	localparam logic [7:0] CODES [8] = '{8'h00, 8'h3c, 8'h5a, 8'h81, 8'hc3, 8'ha5, 8'h69, 8'hff};
	logic                clk = 1'b0;
	logic                rstn = 1'b0;
	logic                en = 1'b0;
	logic                irq_en = 1'b0;
	logic                st_set = 1'b0;
	logic                st_clr = 1'b0;
	logic                ow_clr = 1'b0;
	logic                rd = 1'b0;
	logic [1:0]          sweep = 2'h0;
	logic                rpt = 1'b0;
	logic [CHSEL_W-1:0]  ch = 4'h0;
	logic [DIV_W-1:0]    div = 8'hc7;
	logic [DLY_W-1:0]    dly = 8'h00;
	logic [PTR_W-1:0]    rd_idx = 2'h0;
	logic                start_bit, comp, busy, ow, irq, cmp, sh;
	logic [PTR_W-1:0]    ptr;
	logic [DATA_W-1:0]   ent [4];
	logic [DATA_W-1:0]   exp_e [4];
	logic [DATA_W-1:0]   dac;
	logic [CH_W-1:0]     mux;
	int                  n_mismatch = 0;
	int                  check_count = 0;
	int                  cyc;
	int                  lo;

	always #2.5 clk = ~clk;

	adcs_seq dut (
		.clk(clk), .rstn(rstn), .converter_enable_bit(en), .converter_irq_enable(irq_en),
		.start_set(st_set), .start_clear(st_clr), .sweep_sel(sweep), .repeat_select_bit(rpt),
		.channel_sel(ch), .clk_div(div), .sample_delay(dly), .overwrite_flag_clear(ow_clr),
		.result_read(rd), .result_read_idx(rd_idx), .start_bit(start_bit), .completion_flag(comp),
		.busy_flag(busy), .overwrite_flag(ow), .last_result_pointer(ptr), .converter_irq(irq),
		.result_entry_0(ent[0]), .result_entry_1(ent[1]), .result_entry_2(ent[2]),
		.result_entry_3(ent[3]), .cmp_in(cmp), .mux_sel(mux), .sample_hold(sh), .dac_code(dac)
	);
	adcs_analog_model an (.clk(clk), .mux_sel(mux), .sample_hold(sh), .dac_code(dac), .cmp_in(cmp));

	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
		check_count++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	task automatic print_verdict();
		$display("mismatches %0d checks %0d", n_mismatch, check_count);
		if (n_mismatch == 0 && check_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// enable, then let the analog side settle
	task automatic power_up();
		en <= 1'b1;
		repeat (EN_WAIT) @(posedge clk);
	endtask

	task automatic power_down();
		en <= 1'b0;
		@(posedge clk);
		@(posedge clk);
		chk({start_bit, comp, busy, ow, irq}, 8'h00, "disable clears");
	endtask

	// configure and pulse start, entered just after an edge
	task automatic run(input logic [1:0] sw, input logic rp, input logic [3:0] c, input logic [7:0] dv, dl);
		sweep <= sw;
		rpt <= rp;
		ch <= c;
		div <= dv;
		dly <= dl;
		st_set <= 1'b1;
		@(posedge clk);
		st_set <= 1'b0;
		@(posedge clk);
		chk({start_bit, busy, sh}, 8'h07, "start taken");
		chk(ptr, 8'h03, "pointer load");
		chk(mux, c[2:0], "channel routed");
	endtask

	task automatic wait_comp(input int lim);
		for (cyc = 0; comp !== 1'b1 && cyc < lim; cyc++)
			@(posedge clk);
		chk(comp, 8'h01, "completion");
	endtask

	// back-to-back reads with read strobe held high
	task automatic rd_all(input int first, input int last);
		for (int i = first; i <= last; i++)
		begin
			chk(ent[i], exp_e[i], "entry");
			rd <= 1'b1;
			rd_idx <= PTR_W'(i);
			@(posedge clk);
		end
		rd <= 1'b0;
		@(posedge clk);
		chk({comp, irq}, 8'h00, "read clears completion");
	endtask

	initial
	begin
		#(1_000_000);
		n_mismatch++;
		$display("[FAIL] %0t watchdog expired", $time);
		print_verdict();
	end

	initial
	begin
		for (int i = 0; i < 8; i++)
			an.level[i] = CODES[i];
		repeat (8) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		@(posedge clk);
		chk(ptr, 8'h03, "reset pointer");
		chk({start_bit, comp, busy, ow, irq}, 8'h00, "reset flags");
		power_up();
		// one-shot single, two divider and delay settings
		for (int k = 0; k < 2; k++)
		begin
			run(SWEEP_SINGLE, 1'b0, 4'(5 + 2 * k), 8'(199 + 50 * k), 8'(3 * k));
			wait_comp(6000);
			lo = (3 * k + 9) * (200 + 50 * k);
			check_count++;
			if (cyc < lo || cyc > lo + 3 * (200 + 50 * k) + 8)
			begin
				n_mismatch++;
				$display("[FAIL] %0t conversion took %0d cycles", $time, cyc);
			end
			chk(ent[0], CODES[5 + 2 * k], "one-shot result");
			chk(dac, CODES[5 + 2 * k], "final trial code");
			chk({start_bit, busy, ow, ptr}, 8'h00, "one-shot end");
			chk(irq, 8'(k), "irq gated");
			irq_en <= 1'b1;
			@(posedge clk);
			@(posedge clk);
			chk(irq, 8'h01, "irq raised");
			exp_e[0] = CODES[5 + 2 * k];
			rd_all(0, 0);
		end
		power_down();
		power_up();
		// one-shot scan wrapping past the last channel
		run(SWEEP_SCAN, 1'b0, 4'h6, 8'hc7, 8'h00);
		wait_comp(15000);
		chk({start_bit, busy, ptr}, 8'h03, "scan end");
		for (int i = 0; i < 4; i++)
			exp_e[i] = CODES[(6 + i) % 8];
		rd_all(0, 3);
		power_down();
		power_up();
		// repeating single channel, entry 0 left unread
		run(SWEEP_SINGLE, 1'b1, 4'h3, 8'hc7, 8'h00);
		wait_comp(15000);
		chk({start_bit, ptr}, 8'h07, "fourth write keeps start");
		for (int i = 0; i < 4; i++)
			exp_e[i] = CODES[3];
		rd_all(1, 3);
		st_clr <= 1'b1;
		@(posedge clk);
		st_clr <= 1'b0;
		for (cyc = 0; busy === 1'b1 && cyc < 4000; cyc++)
			@(posedge clk);
		chk({start_bit, comp, ow, ptr}, 8'h0c, "stop after wrap");
		chk(ent[0], CODES[3], "wrapped entry");
		ow_clr <= 1'b1;
		@(posedge clk);
		ow_clr <= 1'b0;
		@(posedge clk);
		chk(ow, 8'h00, "overwrite cleared");
		power_down();
		power_up();
		// repeating scan, then abort mid-conversion
		run(SWEEP_SCAN, 1'b1, 4'h5, 8'hc7, 8'h00);
		wait_comp(15000);
		chk({start_bit, irq, ptr}, 8'h0f, "scan keeps start");
		for (int i = 0; i < 4; i++)
		begin
			chk(ent[i], CODES[(5 + i) % 8], "scan entry");
			exp_e[i] = CODES[(5 + i) % 8];
		end
		// read everything before the wrap reaches entry 0
		rd_all(0, 3);
		repeat (300) @(posedge clk);
		chk(busy, 8'h01, "still running");
		power_down();
		print_verdict();
	end
endmodule
`default_nettype wire
